// >>> core/fta_pkg.sv
// Contract
// - start delay lasts start count plus one ticks; count resets to 18h
// - transition interval lasts transition count plus one ticks; resets to 30h
// - program pulse lasts eight times program count plus one ticks; resets 16h
// - page erase pulse lasts 4096 times count plus one ticks; resets 04h
// - block erase pulse lasts 4096 times count plus one ticks; resets EAh
// - end delay lasts end count plus one ticks; resets to 18h
// - block erase end delay lasts eight times count plus one; resets 3Ch
// - recovery delay lasts recovery count plus one ticks; resets to 04h
// - timing registers take reset values at reset only when flash is idle
// - function word copy captured at reset, read only
// - function word bit 0 low forces usb transceiver low power
// - protection word copy captured at reset, read only, holds boot field
// - code start displacement is word wide, read only, loaded at reset
// - displacement bits 8:0 and 15:13 always read zero
// - displacement bits 12:9 load inverted boot region select at reset
// - alternate copies of auto-read registers return primary values
// - eight timing registers are byte wide and read/write
// - tick is system clock divided by prescale divisor plus one
// - busy flag high during program or erase, rises when request accepted
package fta_pkg;
    localparam int TIM_N = 8;
    localparam int TIM_W = 8;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 4;
    localparam int LEN_W = 21;
    localparam int DIV_W = 5;
    // timing register index = register address
    localparam logic [2:0] IDX_START = 3'h0;
    localparam logic [2:0] IDX_TRAN = 3'h1;
    localparam logic [2:0] IDX_PROG = 3'h2;
    localparam logic [2:0] IDX_PERASE = 3'h3;
    localparam logic [2:0] IDX_MERASE = 3'h4;
    localparam logic [2:0] IDX_END = 3'h5;
    localparam logic [2:0] IDX_MEND = 3'h6;
    localparam logic [2:0] IDX_RCV = 3'h7;
    localparam logic [TIM_N-1:0][TIM_W-1:0] TIM_RST =
        {8'h04, 8'h3c, 8'h18, 8'hea, 8'h04, 8'h16, 8'h30, 8'h18};
    localparam logic [ADDR_W-1:0] ADDR_AR0 = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_AR1 = 4'h9;
    localparam logic [ADDR_W-1:0] ADDR_AR2 = 4'ha;
    localparam logic [ADDR_W-1:0] ADDR_AR0_ALT = 4'hc;
    localparam logic [ADDR_W-1:0] ADDR_AR1_ALT = 4'hd;
    localparam logic [ADDR_W-1:0] ADDR_AR2_ALT = 4'he;
    localparam int SHIFT_ONE = 0;
    localparam int SHIFT_X8 = 3;
    localparam int SHIFT_X4096 = 12;
    localparam int USB_EN_BIT = 0;
    localparam int BOOT_LSB = 0;
    localparam int BOOT_W = 4;
    localparam int CODE_AREA_START_ADDR_LSB = 9;

    typedef enum logic [1:0] {
        FTA_OP_PROG = 2'h0,
        FTA_OP_PAGE = 2'h1,
        FTA_OP_BLOCK = 2'h2
    } fta_op_t;

    typedef enum logic [5:0] {
        FTA_S_IDLE = 6'b000001,
        FTA_S_START = 6'b000010,
        FTA_S_TRAN = 6'b000100,
        FTA_S_PULSE = 6'b001000,
        FTA_S_END = 6'b010000,
        FTA_S_RCV = 6'b100000
    } fta_state_t;

    // phase length in ticks: (count + 1) << shift
    function automatic logic [LEN_W-1:0] phase_len(input logic [TIM_W-1:0] cnt,
                                                  input int shift);
        logic [LEN_W-1:0] base;
        base = LEN_W'(cnt) + LEN_W'(1);
        phase_len = base << shift;
    endfunction : phase_len
endpackage : fta_pkg

// >>> core/fta_prescale.sv
`timescale 1ns/1ps
module fta_prescale #(
    parameter int DIV_W = 5
) (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // sync reset
    input wire logic run, // count while high
    input wire logic [DIV_W-1:0] divisor, // divide by divisor + 1
    output logic tick // one-cycle prescaler output
);
    import fta_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
    } fta_ps_st_t;

    fta_ps_st_t st_r;
    fta_ps_st_t st_nxt;

    assign tick = run && (st_r.cnt == divisor);

    always_comb
    begin
        st_nxt = st_r;
        if (!run || tick)
        begin
            st_nxt.cnt = '0;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + DIV_W'(1);
        end
        if (!reset_n)
        begin
            st_nxt.cnt = '0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        st_r <= st_nxt;
    end

    tick_gap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (tick && divisor != '0 && $stable(divisor)) |=> !tick)
        else $error("prescaler ticks back to back with nonzero divisor");
endmodule : fta_prescale

// >>> core/fta_phase_timer.sv
`timescale 1ns/1ps
module fta_phase_timer #(
    parameter int LEN_W = 21
) (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // sync reset
    input wire logic load, // start a phase
    input wire logic [LEN_W-1:0] len, // phase length in ticks, >= 1
    input wire logic tick, // prescaler output
    output logic done // last tick of phase
);
    import fta_pkg::*;

    typedef struct packed {
        logic armed;
        logic [LEN_W-1:0] cnt;
    } fta_tm_st_t;

    fta_tm_st_t st_r;
    fta_tm_st_t st_nxt;

    assign done = st_r.armed && tick && (st_r.cnt == '0);

    always_comb
    begin
        st_nxt = st_r;
        if (load)
        begin
            st_nxt.armed = 1'b1;
            st_nxt.cnt = len - LEN_W'(1);
        end
        else if (done)
        begin
            st_nxt.armed = 1'b0;
        end
        else if (st_r.armed && tick)
        begin
            st_nxt.cnt = st_r.cnt - LEN_W'(1);
        end
        if (!reset_n)
        begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        st_r <= st_nxt;
    end

    load_count_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        load |=> (st_r.armed && st_r.cnt == $past(len) - LEN_W'(1)))
        else $error("phase timer did not reload its count");
endmodule : fta_phase_timer

// >>> core/fta_flash_timing.sv
`timescale 1ns/1ps
module fta_flash_timing (
    input wire logic clk_sys, // system clock, 50 MHz
    input wire logic reset_n, // device reset, sync, active low
    input wire logic reg_wr, // cpu write strobe
    input wire logic reg_rd, // cpu read strobe
    input wire logic [fta_pkg::ADDR_W-1:0] reg_addr, // register address
    input wire logic [fta_pkg::WORD_W-1:0] reg_wdata, // write data
    output logic [fta_pkg::WORD_W-1:0] reg_rdata, // read data, registered
    output logic reg_rvalid, // read data valid pulse
    input wire logic [fta_pkg::DIV_W-1:0] prescale_divisor, // prescaler field
    input wire logic [fta_pkg::WORD_W-1:0] info_function_word, // info block 0
    input wire logic [fta_pkg::WORD_W-1:0] info_protection_word, // info block 1
    input wire logic op_req, // start program or erase
    input wire fta_pkg::fta_op_t op_kind, // kind of operation
    input wire logic usb_ctrl_low_power, // usb controller wants low power
    output logic flash_busy_flag, // operation in progress
    output logic phase_start, // start delay running
    output logic phase_tran, // transition running
    output logic prog_pulse, // programming pulse
    output logic page_erase_pulse, // page erase pulse
    output logic block_erase_pulse, // block erase pulse
    output logic phase_end, // end delay running
    output logic phase_rcv, // recovery running
    output logic usb_xcvr_low_power // usb transceiver low power
);
    import fta_pkg::*;

    // ============================================================
    // state
    // ============================================================
    typedef struct packed {
        fta_state_t state;
        fta_op_t kind;
        logic [TIM_N-1:0][TIM_W-1:0] tim;
        logic [WORD_W-1:0] func_word;
        logic [WORD_W-1:0] prot_word;
        logic [WORD_W-1:0] disp;
        logic [WORD_W-1:0] rdata;
        logic rvalid;
    } fta_st_t;

    fta_st_t st_r;
    fta_st_t st_nxt;

    logic tick;
    logic done;
    logic tmr_load;
    logic [LEN_W-1:0] tmr_len;

    // ============================================================
    // read decode
    // ============================================================
    function automatic logic [WORD_W-1:0] read_mux(input fta_st_t s,
                                                   input logic [ADDR_W-1:0] a);
        read_mux = '0;
        if (a < ADDR_W'(TIM_N))
        begin
            read_mux = WORD_W'(s.tim[a[2:0]]);
        end
        else if (a == ADDR_AR0 || a == ADDR_AR0_ALT)
        begin
            read_mux = s.func_word;
        end
        else if (a == ADDR_AR1 || a == ADDR_AR1_ALT)
        begin
            read_mux = s.prot_word;
        end
        else if (a == ADDR_AR2 || a == ADDR_AR2_ALT)
        begin
            read_mux = s.disp;
        end
    endfunction : read_mux

    // displacement from protection word
    function automatic logic [WORD_W-1:0] code_disp(input logic [WORD_W-1:0] pw);
        code_disp = '0;
        code_disp[CODE_AREA_START_ADDR_LSB +: BOOT_W] = ~pw[BOOT_LSB +: BOOT_W];
    endfunction : code_disp

    // ============================================================
    // sub blocks
    // ============================================================
    fta_prescale #(
        .DIV_W(DIV_W)
    ) u_prescale (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .run(st_r.state != FTA_S_IDLE),
        .divisor(prescale_divisor),
        .tick(tick)
    );

    fta_phase_timer #(
        .LEN_W(LEN_W)
    ) u_timer (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .load(tmr_load),
        .len(tmr_len),
        .tick(tick),
        .done(done)
    );

    // ============================================================
    // sequencer and registers
    // ============================================================
    always_comb
    begin
        st_nxt = st_r;
        tmr_load = 1'b0;
        tmr_len = phase_len(st_r.tim[IDX_START], SHIFT_ONE);
        st_nxt.rvalid = reg_rd;
        if (reg_rd)
        begin
            st_nxt.rdata = read_mux(st_r, reg_addr);
        end
        if (reg_wr && reg_addr < ADDR_W'(TIM_N))
        begin
            st_nxt.tim[reg_addr[2:0]] = reg_wdata[TIM_W-1:0];
        end
        unique case (st_r.state)
            FTA_S_IDLE:
            begin
                if (op_req)
                begin
                    st_nxt.state = FTA_S_START;
                    st_nxt.kind = op_kind;
                    tmr_load = 1'b1;
                    tmr_len = phase_len(st_r.tim[IDX_START], SHIFT_ONE);
                end
            end
            FTA_S_START:
            begin
                if (done)
                begin
                    st_nxt.state = FTA_S_TRAN;
                    tmr_load = 1'b1;
                    tmr_len = phase_len(st_r.tim[IDX_TRAN], SHIFT_ONE);
                end
            end
            FTA_S_TRAN:
            begin
                if (done)
                begin
                    st_nxt.state = FTA_S_PULSE;
                    tmr_load = 1'b1;
                    unique case (st_r.kind)
                        FTA_OP_PROG:
                            tmr_len = phase_len(st_r.tim[IDX_PROG], SHIFT_X8);
                        FTA_OP_PAGE:
                            tmr_len = phase_len(st_r.tim[IDX_PERASE], SHIFT_X4096);
                        FTA_OP_BLOCK:
                            tmr_len = phase_len(st_r.tim[IDX_MERASE], SHIFT_X4096);
                        default:
                            tmr_len = phase_len(st_r.tim[IDX_PROG], SHIFT_X8);
                    endcase
                end
            end
            FTA_S_PULSE:
            begin
                if (done)
                begin
                    st_nxt.state = FTA_S_END;
                    tmr_load = 1'b1;
                    if (st_r.kind == FTA_OP_BLOCK)
                    begin
                        tmr_len = phase_len(st_r.tim[IDX_MEND], SHIFT_X8);
                    end
                    else
                    begin
                        tmr_len = phase_len(st_r.tim[IDX_END], SHIFT_ONE);
                    end
                end
            end
            FTA_S_END:
            begin
                if (done)
                begin
                    st_nxt.state = FTA_S_RCV;
                    tmr_load = 1'b1;
                    tmr_len = phase_len(st_r.tim[IDX_RCV], SHIFT_ONE);
                end
            end
            FTA_S_RCV:
            begin
                if (done)
                begin
                    st_nxt.state = FTA_S_IDLE;
                end
            end
            default:
            begin
                st_nxt.state = FTA_S_IDLE;
            end
        endcase
        if (!reset_n)
        begin
            st_nxt.state = FTA_S_IDLE;
            st_nxt.kind = FTA_OP_PROG;
            st_nxt.rdata = '0;
            st_nxt.rvalid = 1'b0;
            tmr_load = 1'b0;
            if (st_r.state == FTA_S_IDLE)
            begin
                st_nxt.tim = TIM_RST;
            end
            else
            begin
                st_nxt.tim = st_r.tim;
            end
            st_nxt.func_word = info_function_word;
            st_nxt.prot_word = info_protection_word;
            st_nxt.disp = code_disp(info_protection_word);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        st_r <= st_nxt;
    end

    // ============================================================
    // outputs
    // ============================================================
    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign flash_busy_flag = (st_r.state != FTA_S_IDLE);
    assign phase_start = (st_r.state == FTA_S_START);
    assign phase_tran = (st_r.state == FTA_S_TRAN);
    assign prog_pulse = (st_r.state == FTA_S_PULSE) && (st_r.kind == FTA_OP_PROG);
    assign page_erase_pulse = (st_r.state == FTA_S_PULSE) && (st_r.kind == FTA_OP_PAGE);
    assign block_erase_pulse = (st_r.state == FTA_S_PULSE) && (st_r.kind == FTA_OP_BLOCK);
    assign phase_end = (st_r.state == FTA_S_END);
    assign phase_rcv = (st_r.state == FTA_S_RCV);
    assign usb_xcvr_low_power = !st_r.func_word[USB_EN_BIT] || usb_ctrl_low_power;

    // ============================================================
    // checks
    // ============================================================
    logic [LEN_W-1:0] ph_ticks_r;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || tmr_load)
        begin
            ph_ticks_r <= '0;
        end
        else if (tick)
        begin
            ph_ticks_r <= ph_ticks_r + LEN_W'(1);
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    start_len_a: assert property ((phase_start && done) |->
        ph_ticks_r + LEN_W'(1) == phase_len(st_r.tim[IDX_START], SHIFT_ONE))
        else $error("start delay length wrong");
    tran_len_a: assert property ((phase_tran && done) |->
        ph_ticks_r + LEN_W'(1) == phase_len(st_r.tim[IDX_TRAN], SHIFT_ONE))
        else $error("transition length wrong");
    prog_len_a: assert property ((prog_pulse && done) |->
        ph_ticks_r + LEN_W'(1) == phase_len(st_r.tim[IDX_PROG], SHIFT_X8))
        else $error("program pulse length wrong");
    page_len_a: assert property ((page_erase_pulse && done) |->
        ph_ticks_r + LEN_W'(1) == phase_len(st_r.tim[IDX_PERASE], SHIFT_X4096))
        else $error("page erase pulse length wrong");
    block_len_a: assert property ((block_erase_pulse && done) |->
        ph_ticks_r + LEN_W'(1) == phase_len(st_r.tim[IDX_MERASE], SHIFT_X4096))
        else $error("block erase pulse length wrong");
    end_len_a: assert property ((phase_end && done && st_r.kind != FTA_OP_BLOCK) |->
        ph_ticks_r + LEN_W'(1) == phase_len(st_r.tim[IDX_END], SHIFT_ONE))
        else $error("end delay length wrong");
    block_end_a: assert property ((phase_end && done && st_r.kind == FTA_OP_BLOCK) |->
        ph_ticks_r + LEN_W'(1) == phase_len(st_r.tim[IDX_MEND], SHIFT_X8))
        else $error("block erase end delay length wrong");
    rcv_len_a: assert property ((phase_rcv && done) |->
        ph_ticks_r + LEN_W'(1) == phase_len(st_r.tim[IDX_RCV], SHIFT_ONE))
        else $error("recovery length wrong");
    busy_start_a: assert property ((!flash_busy_flag && op_req) |=>
        (flash_busy_flag && phase_start))
        else $error("request not taken while idle");
    disp_fixed_a: assert property (
        st_r.disp[CODE_AREA_START_ADDR_LSB-1:0] == '0 && st_r.disp[WORD_W-1:CODE_AREA_START_ADDR_LSB+BOOT_W] == '0)
        else $error("fixed displacement bits not zero");
    disp_boot_a: assert property ($rose(reset_n) |->
        st_r.disp[CODE_AREA_START_ADDR_LSB +: BOOT_W] == ~st_r.prot_word[BOOT_LSB +: BOOT_W])
        else $error("displacement not inverse of boot field");
    alias_read_a: assert property ((reg_rd && reg_addr == ADDR_AR2_ALT) |=>
        (reg_rvalid && reg_rdata == st_r.disp))
        else $error("alternate copy differs from primary");
    usb_force_a: assert property (!st_r.func_word[USB_EN_BIT] |->
        usb_xcvr_low_power)
        else $error("transceiver not forced to low power");

    order_tran_a: assert property (
        (phase_start && done) |=> phase_tran)
        else $error("start not followed by transition");
    order_pulse_a: assert property (
        (phase_tran && done) |=> (prog_pulse || page_erase_pulse || block_erase_pulse))
        else $error("transition not followed by pulse");
    order_end_a: assert property (
        (st_r.state == FTA_S_PULSE && done) |=> phase_end)
        else $error("pulse not followed by end delay");
    order_rcv_a: assert property (
        (phase_end && done) |=> phase_rcv)
        else $error("end delay not followed by recovery");
    rcv_idle_a: assert property (
        (phase_rcv && done) |=> !flash_busy_flag)
        else $error("busy stayed after recovery");
    hold_phase_a: assert property (
        (flash_busy_flag && !done) |=> $stable(st_r.state))
        else $error("phase left before its end");

    hi_byte_a: assert property (
        (reg_rd && reg_addr < ADDR_W'(TIM_N)) |=> reg_rdata[WORD_W-1:TIM_W] == '0)
        else $error("timing register high byte not zero");
    wr_land_a: assert property (
        (reg_wr && reg_addr < ADDR_W'(TIM_N)) |=>
        st_r.tim[3'($past(reg_addr))] == TIM_W'($past(reg_wdata)))
        else $error("timing register write lost");
    rvalid_a: assert property (
        reg_rd |=> reg_rvalid)
        else $error("read not answered");
    ro_keep_a: assert property (
        reg_wr |=> ($stable(st_r.func_word) && $stable(st_r.prot_word) && $stable(st_r.disp)))
        else $error("read-only copy changed by a write");

    capture_a: assert property (disable iff (1'b0)
        !reset_n |=> (st_r.func_word == $past(info_function_word) &&
        st_r.prot_word == $past(info_protection_word)))
        else $error("info words not captured at reset");
    keep_busy_a: assert property (disable iff (1'b0)
        (!reset_n && flash_busy_flag) |=> st_r.tim == $past(st_r.tim))
        else $error("reset while busy altered timing registers");
    load_idle_a: assert property (disable iff (1'b0)
        (!reset_n && !flash_busy_flag) |=> st_r.tim == TIM_RST)
        else $error("reset while idle missed defaults");
endmodule : fta_flash_timing

// >>> test/fta_flash_array_model.sv
`timescale 1ns/1ps
// ====================================================================
// flash array side: measures how long each control phase is held
module fta_flash_array_model (
    input wire logic clk_sys, // system clock
    input wire logic clr, // clear all counts
    input wire logic flash_busy_flag, // busy from controller
    input wire logic phase_start, // start delay
    input wire logic phase_tran, // transition
    input wire logic prog_pulse, // programming pulse
    input wire logic page_erase_pulse, // page erase pulse
    input wire logic block_erase_pulse, // block erase pulse
    input wire logic phase_end, // end delay
    input wire logic phase_rcv, // recovery
    output int n_busy, // busy cycles
    output int n_start, // start cycles
    output int n_tran, // transition cycles
    output int n_pulse, // pulse cycles
    output int n_end, // end cycles
    output int n_rcv, // recovery cycles
    output logic [2:0] kinds_seen // block, page, prog
);
    always @(posedge clk_sys)
    begin
        if (clr)
        begin
            n_busy <= 0;
            n_start <= 0;
            n_tran <= 0;
            n_pulse <= 0;
            n_end <= 0;
            n_rcv <= 0;
            kinds_seen <= 3'h0;
        end
        else
        begin
            n_busy <= n_busy + int'(flash_busy_flag);
            n_start <= n_start + int'(phase_start);
            n_tran <= n_tran + int'(phase_tran);
            n_pulse <= n_pulse + int'(prog_pulse | page_erase_pulse | block_erase_pulse);
            n_end <= n_end + int'(phase_end);
            n_rcv <= n_rcv + int'(phase_rcv);
            kinds_seen <= kinds_seen | {block_erase_pulse, page_erase_pulse, prog_pulse};
        end
    end
endmodule : fta_flash_array_model

// >>> test/fta_flash_timing_tb_top.sv
`timescale 1ns/1ps
module fta_flash_timing_tb_top;
    import fta_pkg::*;
    typedef struct {fta_op_t kind; int div; bit dup; int p; int e;} fta_row_t;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [WORD_W-1:0] reg_wdata = 16'h0000;
    logic [WORD_W-1:0] reg_rdata;
    logic reg_rvalid;
    logic [DIV_W-1:0] prescale_divisor = 5'h00;
    logic [WORD_W-1:0] info_function_word = 16'h0001;
    logic [WORD_W-1:0] info_protection_word = 16'hab05;
    logic op_req = 1'b0;
    fta_op_t op_kind = FTA_OP_PROG;
    logic usb_ctrl_low_power = 1'b0;
    logic flash_busy_flag, phase_start, phase_tran, prog_pulse, page_erase_pulse;
    logic block_erase_pulse, phase_end, phase_rcv, usb_xcvr_low_power;
    logic clr = 1'b0;
    int n_busy, n_start, n_tran, n_pulse, n_end, n_rcv;
    logic [2:0] kinds_seen;
    int failures = 0;
    int cmp_count = 0;
    logic [15:0] rd;
    logic [15:0] dflt [16] = '{16'h0018, 16'h0030, 16'h0016, 16'h0004, 16'h00ea, 16'h0018,
        16'h003c, 16'h0004, 16'h0001, 16'hab05, 16'h1400, 16'h0000, 16'h0001, 16'hab05,
        16'h1400, 16'h0000};
    logic [7:0] tim [8] = '{8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01};
    fta_row_t ops [5] = '{'{FTA_OP_PROG, 0, 0, 8, 2}, '{FTA_OP_PROG, 3, 0, 8, 2},
        '{FTA_OP_PAGE, 1, 0, 4096, 2}, '{FTA_OP_BLOCK, 1, 0, 4096, 8}, '{FTA_OP_PROG, 0, 1, 8, 2}};

    fta_flash_timing uut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .prescale_divisor(prescale_divisor),
        .info_function_word(info_function_word), .info_protection_word(info_protection_word),
        .op_req(op_req), .op_kind(op_kind), .usb_ctrl_low_power(usb_ctrl_low_power),
        .flash_busy_flag(flash_busy_flag), .phase_start(phase_start), .phase_tran(phase_tran),
        .prog_pulse(prog_pulse), .page_erase_pulse(page_erase_pulse),
        .block_erase_pulse(block_erase_pulse), .phase_end(phase_end), .phase_rcv(phase_rcv),
        .usb_xcvr_low_power(usb_xcvr_low_power));

    fta_flash_array_model flash (.clk_sys(clk_sys), .clr(clr),
        .flash_busy_flag(flash_busy_flag), .phase_start(phase_start), .phase_tran(phase_tran),
        .prog_pulse(prog_pulse), .page_erase_pulse(page_erase_pulse),
        .block_erase_pulse(block_erase_pulse), .phase_end(phase_end), .phase_rcv(phase_rcv),
        .n_busy(n_busy), .n_start(n_start), .n_tran(n_tran), .n_pulse(n_pulse),
        .n_end(n_end), .n_rcv(n_rcv), .kinds_seen(kinds_seen));

    always #10 clk_sys = ~clk_sys;

    // ================================================================
    // shared tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task finish_test;
        $display("compares %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    task reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check(32'(reg_rvalid), 32'h1);
        d = reg_rdata;
    endtask : reg_read

    // only called while the flash is idle
    task reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write

    task wait_idle;
        int i;
        for (i = 0; i < 20000 && flash_busy_flag !== 1'b0; i++)
        begin
            @(posedge clk_sys);
            #1;
        end
        if (i == 20000)
        begin
            failures++;
            $display("wrong value at %0t: busy never dropped", $time);
            finish_test();
        end
    endtask : wait_idle

    task do_reset(input int n);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (n) @(posedge clk_sys);
        reset_n <= 1'b1;
        #1;
    endtask : do_reset

    // ================================================================
    // main sequence
    initial
    begin
        int s, p, e;
        do_reset(9);
        for (int a = 0; a < 16; a++)
        begin
            reg_read(4'(a), rd);
            check(32'(rd), 32'(dflt[a]));
        end
        for (int a = 0; a < 8; a++)
        begin
            reg_write(4'(a), 16'hff40 + 16'(a));
            reg_read(4'(a), rd);
            check(32'(rd), 32'h40 + 32'(a));
        end
        reg_write(4'h9, 16'hffff);
        reg_write(4'ha, 16'hffff);
        reg_read(4'h9, rd);
        check(32'(rd), 32'hab05);
        reg_read(4'he, rd);
        check(32'(rd), 32'h1400);
        for (int a = 0; a < 8; a++)
            reg_write(4'(a), {8'h00, tim[a]});
        $display("register test done");
        for (int r = 0; r < 5; r++)
        begin
            @(posedge clk_sys);
            prescale_divisor <= 5'(ops[r].div);
            op_req <= 1'b1;
            op_kind <= ops[r].kind;
            clr <= 1'b1;
            @(posedge clk_sys);
            op_req <= 1'b0;
            clr <= 1'b0;
            #1;
            check(32'(flash_busy_flag), 32'h1);
            if (ops[r].dup)
            begin
                @(posedge clk_sys);
                op_req <= 1'b1;
                op_kind <= FTA_OP_BLOCK;
                @(posedge clk_sys);
                op_req <= 1'b0;
            end
            wait_idle();
            s = ops[r].div + 1;
            p = ops[r].p;
            e = ops[r].e;
            check(32'(n_start), 32'(3 * s));
            check(32'(n_tran), 32'(2 * s));
            check(32'(n_pulse), 32'(p * s));
            check(32'(n_end), 32'(e * s));
            check(32'(n_rcv), 32'(2 * s));
            check(32'(n_busy), 32'((7 + p + e) * s));
            check(32'(kinds_seen), 32'(1) << ops[r].kind);
            $display("operation row %0d done", r);
        end
        check(32'(usb_xcvr_low_power), 32'h0);
        @(posedge clk_sys);
        usb_ctrl_low_power <= 1'b1;
        @(posedge clk_sys);
        #1;
        check(32'(usb_xcvr_low_power), 32'h1);
        $display("usb test done");
        @(posedge clk_sys);
        usb_ctrl_low_power <= 1'b0;
        op_req <= 1'b1;
        op_kind <= FTA_OP_BLOCK;
        @(posedge clk_sys);
        op_req <= 1'b0;
        repeat (20) @(posedge clk_sys);
        info_function_word <= 16'h0000;
        info_protection_word <= 16'h000f;
        do_reset(1);
        check(32'(flash_busy_flag), 32'h0);
        check(32'(usb_xcvr_low_power), 32'h1);
        reg_read(4'h0, rd);
        check(32'(rd), 32'h0002);
        reg_read(4'hc, rd);
        check(32'(rd), 32'h0000);
        reg_read(4'ha, rd);
        check(32'(rd), 32'h0000);
        do_reset(10);
        reg_read(4'h0, rd);
        check(32'(rd), 32'h0018);
        reg_read(4'h9, rd);
        check(32'(rd), 32'h000f);
        $display("reset while busy test done");
        finish_test();
    end
endmodule : fta_flash_timing_tb_top
